// File: design/gpio_port_defines.svh
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH
// Pin count and pin-function field
`define GPIO_PIN_COUNT      19
`define GPIO_FUNC_LSB       4
`define GPIO_FUNC_MSB       5
`define GPIO_FUNC_PLAIN     2'b00
`define GPIO_FUNC_CLOCKS    2'b01
// Reset values
`define GPIO_OUT_RESET      19'h00000
`define GPIO_DIR_RESET      19'h00000
`define GPIO_IE_RESET       19'h00000
// Debounce: samples needed to accept a level, largest divider code
`define GPIO_DEB_SAMPLES    2
`define GPIO_DIV_MAX_CODE   3'h7
`endif

// File: design/gpio_port_pkg.sv
package gpio_port_pkg;
  // Pin role chosen by the function field
  typedef enum logic [1:0] {
    func_plain  = 2'b00,
    func_clocks = 2'b01,
    func_printa = 2'b10,
    func_printb = 2'b11
  } pin_func_type;
endpackage

// File: design/debounce_cell.sv
`timescale 1ns/100ps
`include "gpio_port_defines.svh"
module debounce_cell #(
  parameter int SAMPLES = `GPIO_DEB_SAMPLES
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic sample_en,   // Debounce sample strobe
  input  wire logic raw_in,      // Synchronised pin level
  output logic      level_out    // Accepted level
);
  initial begin
    if (SAMPLES < 1 || SAMPLES > 15) $error("debounce_cell: SAMPLES out of range");
  end

  logic       level_q;           // Accepted level
  logic       level_d;
  logic [3:0] count_q;           // Matching samples seen
  logic [3:0] count_d;

  // Accept a new level only after SAMPLES consecutive strobes see it
  always_comb begin
    level_d = level_q;
    count_d = count_q;
    if (sample_en) begin
      if (raw_in == level_q) begin
        count_d = 4'h0;          // Glitch gone, restart window
      end else if (count_q == 4'(SAMPLES - 1)) begin
        level_d = raw_in;        // RULE_10
        count_d = 4'h0;
      end else begin
        count_d = count_q + 4'h1;
      end
    end
  end

  // Register only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= 1'b0;
      count_q <= 4'h0;
    end else begin
      level_q <= level_d;
      count_q <= count_d;
    end
  end

  assign level_out = level_q;
endmodule

// File: design/gpio_port.sv
`timescale 1ns/100ps
`include "gpio_port_defines.svh"
// Overview of operation
// RULE_01 - Nineteen pins, each programmable input or output
// RULE_02 - Two-bit function field selects pin roles
// RULE_03 - After reset every pin input, driver off; code still drives pins 15-16 (grants) in function 0x
// RULE_04 - Function 0x: pins 15-18 extra grant/request
// RULE_05 - Function 01: pins 10-12 output clocks
// RULE_06 - Function 1x: pins serve printer port
// RULE_07 - Pins 13 and 14 always programmable
// RULE_08 - Separate rise and fall interrupts per line
// RULE_09 - Pin input feeds debounce filter directly; code passes it through a two-flop synchroniser first
// RULE_10 - New level accepted after two samples
// RULE_11 - Sample clock from base to base/128
// RULE_12 - Accepted change raises interrupt, captures level
// RULE_13 - Short pulses ignored entirely
// RULE_14 - Software sets data, direction, enables; sticky
// RULE_15 - All logic on system clock, strobe enable
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int PINS = `GPIO_PIN_COUNT
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // Pins: output enable low while driving
  input  wire logic [PINS-1:0]   pin_in,
  output logic [PINS-1:0]        pin_out,
  output logic [PINS-1:0]        pin_oe_n,
  // Configuration
  input  wire logic [7:0]        func_ctrl,         // Bits 5:4 hold pin function
  input  wire logic [PINS-1:0]   out_data,          // Software output data
  input  wire logic [PINS-1:0]   out_dir,           // 1 = output
  input  wire logic [PINS-1:0]   rise_ie,           // Rising interrupt enable
  input  wire logic [PINS-1:0]   fall_ie,           // Falling interrupt enable
  input  wire logic [PINS-1:0]   rise_clear,        // Clear pulse per flag
  input  wire logic [PINS-1:0]   fall_clear,
  input  wire logic [2:0]        debounce_div,      // Divide by 2**code
  input  wire logic              timer_base_clock,  // Base strobe, one cycle
  // Alternate function sources and sinks
  input  wire logic              extra_bus_grant_a,
  input  wire logic              extra_bus_grant_b,
  output logic                   extra_bus_request_a,
  output logic                   extra_bus_request_b,
  input  wire logic              processor_clock,
  input  wire logic              mem_clk_ctl,
  input  wire logic              mem_clk_data,
  input  wire logic [7:0]        printer_data_bus_out,
  input  wire logic              printer_data_bus_oe,
  output logic [7:0]             printer_data_bus_in,
  input  wire logic [3:0]        printer_ctl_out,   // nInit,nSelectIn,nAutoFd,nStrobe
  output logic [4:0]             printer_status_in, // Select,PError,nFault,nAck,Busy
  // Status
  output logic [PINS-1:0]        in_data,           // Input data register
  output logic [PINS-1:0]        rise_pend,
  output logic [PINS-1:0]        fall_pend,
  output logic                   pin_interrupt
);
  initial begin
    if (PINS != `GPIO_PIN_COUNT) $error("gpio_port: pin map needs 19 pins");
  end

  pin_func_type   func;            // Decoded pin function
  logic [PINS-1:0] alt_mask;       // Pin taken by an alternate role
  logic [PINS-1:0] alt_out;        // Alternate output value
  logic [PINS-1:0] alt_drive;      // Alternate role drives the pin

  assign func = pin_func_type'(func_ctrl[`GPIO_FUNC_MSB:`GPIO_FUNC_LSB]); // RULE_02

  // Pin role map per function setting
  always_comb begin
    alt_mask  = '0;
    alt_out   = '0;
    alt_drive = '0;
    if (func[1]) begin
      alt_mask[12:0]   = 13'h1fff;                // RULE_06
      alt_mask[18:15]  = 4'hf;
      alt_out[7:0]     = printer_data_bus_out;
      alt_drive[7:0]   = {8{printer_data_bus_oe}};
      alt_out[9:8]     = printer_ctl_out[1:0];
      alt_drive[9:8]   = 2'h3;
      alt_out[16:15]   = printer_ctl_out[3:2];
      alt_drive[16:15] = 2'h3;
    end else begin
      alt_mask[18:15]  = 4'hf;                    // RULE_04
      alt_out[15]      = extra_bus_grant_a;
      alt_out[16]      = extra_bus_grant_b;
      alt_drive[16:15] = 2'h3;
      if (func == func_clocks) begin
        alt_mask[12:10]  = 3'h7;                  // RULE_05
        alt_out[10]      = processor_clock;
        alt_out[11]      = mem_clk_ctl;
        alt_out[12]      = mem_clk_data;
        alt_drive[12:10] = 3'h7;
      end
    end
    alt_mask[14:13] = 2'h0;                       // RULE_07
  end

  // Output mux; out_dir zero makes every plain pin input, alternate-role pins are driven by alt_drive alone
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (alt_mask[i]) begin
        pin_out[i]  = alt_out[i];
        pin_oe_n[i] = ~alt_drive[i];
      end else begin
        pin_out[i]  = out_data[i];                // RULE_01
        pin_oe_n[i] = ~out_dir[i];                // RULE_03
      end
    end
  end

  // Two-flop pin synchroniser; first stage feeds only the second
  logic [PINS-1:0] sync1_q;
  logic [PINS-1:0] sync2_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Alternate inputs take the synchronised raw level
  assign extra_bus_request_a = sync2_q[17];
  assign extra_bus_request_b = sync2_q[18];
  assign printer_data_bus_in = sync2_q[7:0];
  assign printer_status_in   = {sync2_q[10], sync2_q[11], sync2_q[12], sync2_q[17], sync2_q[18]};

  // Debounce strobe: base strobe divided by 1..128, still on clk_sys
  logic [6:0] div_q;               // Base strobes seen
  logic [6:0] div_d;
  logic [6:0] div_limit;           // Terminal count
  logic       sample_q;            // Debounce sample strobe
  logic       sample_d;
  assign div_limit = 7'((8'h01 << debounce_div) - 8'h01); // RULE_11

  always_comb begin
    div_d    = div_q;
    sample_d = 1'b0;
    if (timer_base_clock) begin                   // RULE_15
      if (div_q >= div_limit) begin
        div_d    = 7'h00;
        sample_d = 1'b1;
      end else begin
        div_d = div_q + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q    <= 7'h00;
      sample_q <= 1'b0;
    end else begin
      div_q    <= div_d;
      sample_q <= sample_d;
    end
  end

  // One filter per pin, fed from the second synchroniser stage
  logic [PINS-1:0] deb;            // Filtered levels
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_deb
      debounce_cell #(.SAMPLES(`GPIO_DEB_SAMPLES)) u_deb (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .sample_en (sample_q),
        .raw_in    (sync2_q[g]),               // RULE_09
        .level_out (deb[g])
      );
    end
  endgenerate

  // Edge flags and input data latch
  logic [PINS-1:0] deb_prev_q;     // Filtered level last cycle
  logic [PINS-1:0] in_data_q;
  logic [PINS-1:0] in_data_d;
  logic [PINS-1:0] rise_q;
  logic [PINS-1:0] rise_d;
  logic [PINS-1:0] fall_q;
  logic [PINS-1:0] fall_d;
  logic [PINS-1:0] rise_ev;
  logic [PINS-1:0] fall_ev;

  // Only a change that passed the filter counts, so glitches leave no trace
  always_comb begin
    rise_ev   = deb & ~deb_prev_q;                // RULE_13
    fall_ev   = ~deb & deb_prev_q;
    in_data_d = in_data_q;
    if ((rise_ev | fall_ev) != '0) begin
      in_data_d = deb;                            // RULE_12
    end
    // Set wins over a same-cycle clear
    rise_d = (rise_q & ~rise_clear) | (rise_ev & rise_ie); // RULE_08
    fall_d = (fall_q & ~fall_clear) | (fall_ev & fall_ie); // RULE_14
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      deb_prev_q <= '0;
      in_data_q  <= '0;
      rise_q     <= `GPIO_IE_RESET;
      fall_q     <= `GPIO_IE_RESET;
    end else begin
      deb_prev_q <= deb;
      in_data_q  <= in_data_d;
      rise_q     <= rise_d;
      fall_q     <= fall_d;
    end
  end

  assign in_data       = in_data_q;
  assign rise_pend     = rise_q;
  assign fall_pend     = fall_q;
  assign pin_interrupt = |(rise_q | fall_q);      // RULE_12
endmodule

// File: tb/pin_board.sv
`timescale 1ns/100ps
// Board side of the pins: a driven wire reads back its driver
module pin_board (
  input  wire logic [18:0] pin_out,
  input  wire logic [18:0] pin_oe_n,
  input  wire logic [18:0] board_level,  // Level the board puts on free wires
  output logic [18:0]      pin_in
);
  // Wire level from both parties; the board never fights a driver
  always_comb begin
    pin_in = (pin_out & ~pin_oe_n) | (board_level & pin_oe_n);
  end
endmodule

// File: tb/gpio_port_assertions.sv
`timescale 1ns/100ps
module gpio_port_assertions #(
  parameter int PINS = 19
) (
  input wire logic            clk_sys,
  input wire logic            reset_n,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe_n,
  input wire logic [7:0]      func_ctrl,
  input wire logic [PINS-1:0] out_data,
  input wire logic [PINS-1:0] out_dir,
  input wire logic [PINS-1:0] rise_clear,
  input wire logic            extra_bus_grant_a,
  input wire logic            processor_clock,
  input wire logic            mem_clk_data,
  input wire logic [3:0]      printer_ctl_out,
  input wire logic [PINS-1:0] in_data,
  input wire logic [PINS-1:0] rise_pend,
  input wire logic [PINS-1:0] fall_pend,
  input wire logic            pin_interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // A rising flag must come with the accepted level
  sequence rise_seen;
    $rose(rise_pend[0]);
  endsequence
  keep_pins_a: assert property (pin_oe_n[14:13] == ~out_dir[14:13])
    else $error("pins 13-14 left plain io");
  plain_io_a: assert property (func_ctrl[5:4] == 2'h0 |-> pin_oe_n[9:0] == ~out_dir[9:0]
    && ((pin_out[9:0] ^ out_data[9:0]) & out_dir[9:0]) == 10'h0) else $error("plain io wrong");
  grant_route_a: assert property (!func_ctrl[5] |-> !pin_oe_n[15]
    && pin_out[15] == extra_bus_grant_a) else $error("grant not on pin 15");
  clock_route_a: assert property (func_ctrl[5:4] == 2'h1 |-> !pin_oe_n[10]
    && pin_out[10] == processor_clock && pin_out[12] == mem_clk_data) else $error("clock pins");
  printer_route_a: assert property (func_ctrl[5] |-> pin_out[16] == printer_ctl_out[3]
    && pin_oe_n[18:17] == 2'h3) else $error("printer pins wrong");
  flag_sticky_a: assert property (rise_pend[0] && !rise_clear[0] |=> rise_pend[0])
    else $error("flag dropped");
  rise_cause_a: assert property (rise_seen |-> $rose(in_data[0]))
    else $error("rise flag without rise");
  fall_cause_a: assert property ($rose(fall_pend[0]) |-> $fell(in_data[0]))
    else $error("fall flag without fall");
  irq_merge_a: assert property (pin_interrupt == (|{rise_pend, fall_pend}))
    else $error("interrupt not flag or");
endmodule
bind gpio_port gpio_port_assertions #(.PINS(PINS)) u_chk (.clk_sys, .reset_n, .pin_out,
  .pin_oe_n, .func_ctrl, .out_data, .out_dir, .rise_clear, .extra_bus_grant_a, .processor_clock,
  .mem_clk_data, .printer_ctl_out, .in_data, .rise_pend, .fall_pend, .pin_interrupt);

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
  import gpio_port_pkg::*;
  logic        clk_sys, reset_n, timer_base_clock, printer_data_bus_oe, pin_interrupt;
  logic        extra_bus_grant_a, extra_bus_grant_b, processor_clock, mem_clk_ctl, mem_clk_data;
  logic        extra_bus_request_a, extra_bus_request_b;
  logic [7:0]  func_ctrl, printer_data_bus_out, printer_data_bus_in;
  logic [3:0]  printer_ctl_out;
  logic [4:0]  printer_status_in;
  logic [2:0]  debounce_div;
  logic [18:0] pin_in, pin_out, pin_oe_n, board, out_data, out_dir, rise_ie, fall_ie;
  logic [18:0] rise_clear, fall_clear, in_data, rise_pend, fall_pend;
  logic [18:0] pexp;  // Expected drive value on every driven pin
  logic [31:0] lfsr;
  int          err_total, checked, cyc, m_lvl, m_rise, m_fall;  // Model level and flags
  localparam int MASK = 'h67fff;  // Pins 15-16 read back grants held low
  gpio_port u_dut (.*);
  pin_board u_board (.pin_out, .pin_oe_n, .board_level(board), .pin_in);
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected driver-off mask per function code
  function automatic logic [18:0] oe_exp(input logic [1:0] f, input logic [18:0] d, input logic p);
    logic [18:0] o;
    o = {4'b1100, ~d[14:0]};
    if (f == 2'h1) o[12:10] = 3'h0;
    if (f[1]) o = {4'b1100, ~d[14:13], 5'b11100, {8{~p}}};
    return o;
  endfunction
  task automatic cmp(input string nm, input logic [18:0] e, input logic [18:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // New board level: nothing may land within one sample period
  task automatic step(input int v, input int d);
    int old;
    old = m_lvl;
    board = v[18:0];
    repeat (1 << d) @(negedge clk_sys);
    cmp("early", old[18:0], in_data);
    repeat ((2 << d) + 12) @(negedge clk_sys);
    m_rise |= v & ~old & rise_ie;
    m_fall |= ~v & old & fall_ie;
    m_lvl = v;
    cmp("in_data", m_lvl[18:0], in_data);
    cmp("rise", m_rise[18:0], rise_pend);
    cmp("fall", m_fall[18:0], fall_pend);
    cmp("irq", 19'((m_rise | m_fall) != 0), 19'(pin_interrupt));
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    {reset_n, printer_data_bus_oe, extra_bus_grant_a, extra_bus_grant_b} = 0;
    {processor_clock, mem_clk_ctl, mem_clk_data, printer_ctl_out, func_ctrl} = 0;
    {printer_data_bus_out, debounce_div, board, out_data, out_dir} = 0;
    {rise_ie, fall_ie, rise_clear, fall_clear} = 0;
    {err_total, checked, cyc, m_lvl, m_rise, m_fall} = 0;
    timer_base_clock = 1;
    lfsr = 32'heaae;
    repeat (4) @(negedge clk_sys);
    reset_n = 1;
    cmp("oe_rst", oe_exp(2'h0, 19'h0, 1'b0), pin_oe_n);
    cmp("in_rst", 19'h0, in_data);
    func_ctrl = 8'hcf;
    // Every divider code; divider settles before each new level
    for (int d = 0; d < 8; d++) begin
      debounce_div = 3'(d);
      repeat (260) @(negedge clk_sys);
      lfsr = nxt(lfsr);
      {rise_ie, fall_ie} = {lfsr[18:0], lfsr[31:13]};
      step(lfsr & MASK, d);
    end
    // One-cycle glitch on every pin but 15-16 is dropped
    board = ~m_lvl[18:0] & MASK[18:0];
    @(negedge clk_sys);
    board = m_lvl[18:0];
    repeat (40) @(negedge clk_sys);
    cmp("pulse", m_lvl[18:0], in_data);
    cmp("pulse_flag", m_rise[18:0], rise_pend);
    {rise_clear, fall_clear, rise_ie, fall_ie} = {38'h3fffffffff, 38'h0};
    @(negedge clk_sys);
    {rise_clear, fall_clear, m_rise, m_fall} = 0;
    @(negedge clk_sys);
    cmp("clear", 19'h0, rise_pend | fall_pend);
    step(~m_lvl & MASK, 7);
    // Pin roles under each function code, random sources
    for (int f = 0; f < 4; f++) begin
      repeat (3) begin
        lfsr = nxt(lfsr);
        func_ctrl = {lfsr[7:6], 2'(f), lfsr[3:0]};
        {out_data, out_dir, board} = {lfsr[18:0], lfsr[31:13], lfsr[27:9]};
        {extra_bus_grant_a, extra_bus_grant_b, processor_clock, mem_clk_ctl} = lfsr[3:0];
        {mem_clk_data, printer_ctl_out, printer_data_bus_oe} = lfsr[9:4];
        printer_data_bus_out = lfsr[17:10];
        repeat (3) @(negedge clk_sys);
        cmp("oe", oe_exp(2'(f), out_dir, printer_data_bus_oe), pin_oe_n);
        cmp("req", board[18:17], {extra_bus_request_b, extra_bus_request_a});
        // Driven pins carry the source that their role selects
        pexp = out_data;
        if (f < 2) pexp[16:15] = {extra_bus_grant_b, extra_bus_grant_a};
        if (f == 1) pexp[12:10] = {mem_clk_data, mem_clk_ctl, processor_clock};
        if (f > 1) pexp[16:0] = {printer_ctl_out[3:2], pexp[14:10], printer_ctl_out[1:0],
                                 printer_data_bus_out};
        cmp("pout", pexp & ~pin_oe_n, pin_out & ~pin_oe_n);
        if (f > 1) begin
          cmp("status", {board[10], board[11], board[12], board[17], board[18]}, printer_status_in);
          cmp("pdata", printer_data_bus_oe ? printer_data_bus_out : board[7:0], printer_data_bus_in);
        end
      end
    end
    tally_and_finish();
  end
endmodule
